// ==== src/opc_pkg.sv ====
// ==========================================================
// Output path control constants and types
// ==========================================================
package opc_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] OPC_IDX_POWER  = 8'h04;
    localparam logic [7:0] OPC_IDX_MIX_L  = 8'h27;
    localparam logic [7:0] OPC_IDX_MIX_R  = 8'h2a;
    localparam logic [7:0] OPC_IDX_VOL_LA = 8'h2e;
    localparam logic [7:0] OPC_IDX_VOL_RA = 8'h2f;
    localparam logic [7:0] OPC_IDX_VOL_LB = 8'h30;
    localparam logic [7:0] OPC_IDX_VOL_RB = 8'h31;

    // Slot of each register in the local array
    localparam int OPC_NREG       = 7;
    localparam int OPC_SLOT_POWER = 0;
    localparam int OPC_SLOT_MIX_L = 1;
    localparam int OPC_SLOT_MIX_R = 2;
    localparam int OPC_SLOT_VOL   = 3;

    // Reset values and writable-bit masks
    localparam logic [7:0] OPC_RST_POWER  = 8'hc0;
    localparam logic [7:0] OPC_RST_MIX    = 8'h38;
    localparam logic [7:0] OPC_RST_VOL    = 8'h00;
    localparam logic [7:0] OPC_MASK_POWER = 8'hfc;
    localparam logic [7:0] OPC_MASK_MIX   = 8'hf8;
    localparam logic [7:0] OPC_MASK_VOL   = 8'h3f;

    // Field positions and widths
    localparam int OPC_BIT_LPDN     = 7;
    localparam int OPC_BIT_RPDN     = 6;
    localparam int OPC_BIT_DRV_EN   = 5;
    localparam int OPC_BIT_CONV_MIX = 7;
    localparam int OPC_BIT_IN_MIX   = 6;
    localparam int OPC_GAIN_LSB     = 3;
    localparam int OPC_GAIN_W       = 3;
    localparam int OPC_LEVEL_W      = 6;
    localparam int OPC_SEL_W        = 2;
    localparam int OPC_ADDR_W       = 12;

    // Tables indexed by slot
    localparam logic [6:0][7:0] OPC_REG_IDX = {
        OPC_IDX_VOL_RB, OPC_IDX_VOL_LB, OPC_IDX_VOL_RA, OPC_IDX_VOL_LA,
        OPC_IDX_MIX_R, OPC_IDX_MIX_L, OPC_IDX_POWER};
    localparam logic [6:0][7:0] OPC_REG_RST = {
        OPC_RST_VOL, OPC_RST_VOL, OPC_RST_VOL, OPC_RST_VOL,
        OPC_RST_MIX, OPC_RST_MIX, OPC_RST_POWER};
    localparam logic [6:0][7:0] OPC_REG_MASK = {
        OPC_MASK_VOL, OPC_MASK_VOL, OPC_MASK_VOL, OPC_MASK_VOL,
        OPC_MASK_MIX, OPC_MASK_MIX, OPC_MASK_POWER};

    // Bus handshake states
    typedef enum logic [1:0] {
        OPC_ST_IDLE   = 2'b01,
        OPC_ST_ACCESS = 2'b10
    } opc_apb_state_t;

    // Settings handed to the analog path; drivers ordered la, ra, lb, rb
    typedef struct packed {
        logic                               left_converter_power_down;
        logic                               right_converter_power_down;
        logic [3:0]                         drv_enable;
        logic [3:0][OPC_LEVEL_W-1:0]        drv_level;
        logic                               left_converter_to_mixer_enable;
        logic                               left_input_to_mixer_enable;
        logic [OPC_GAIN_W-1:0]              left_input_mixer_gain;
        logic                               right_converter_to_mixer_enable;
        logic                               right_input_to_mixer_enable;
        logic [OPC_GAIN_W-1:0]              right_input_mixer_gain;
        logic [3:0][OPC_GAIN_W-1:0]         drv_mix_gain;
        logic [OPC_SEL_W-1:0]               left_input_route;
        logic [OPC_SEL_W-1:0]               right_input_route;
    } opc_path_cfg_t;

    // One-hot slot of a byte address, zero when unmapped
    function automatic logic [6:0] opc_decode(
        input logic [OPC_ADDR_W-1:0] addr);
        logic [6:0] hit;
        hit = '0;
        for (int i = 0; i < OPC_NREG; i++) begin
            if (addr == {2'b00, OPC_REG_IDX[i], 2'b00}) begin
                hit[i] = 1'b1;
            end
        end
        return hit;
    endfunction : opc_decode

endpackage : opc_pkg

// ==== src/opc_cfg_reg.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// One configuration register with reserved bits held at zero
// ==========================================================
module opc_cfg_reg
    import opc_pkg::*;
#(
    parameter logic [7:0] RST  = 8'h00,
    parameter logic [7:0] MASK = 8'hff
) (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Write port
    input  wire logic       wr_en,
    input  wire logic [7:0] wdata,
    // Stored value
    output logic      [7:0] value_q
);

    logic [7:0] value_d;

    // Masking at write time keeps reserved bits zero on readback
    always_comb begin
        value_d = value_q;
        if (wr_en) begin
            value_d = wdata & MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_q <= RST;
        end else begin
            value_q <= value_d;
        end
    end

endmodule : opc_cfg_reg
`default_nettype wire

// ==== src/opc_apb_port.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// APB slave handshake, one wait-free access per transfer
// ==========================================================
module opc_apb_port
    import opc_pkg::*;
(
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB request
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [OPC_ADDR_W-1:0] paddr,
    // APB answer
    output logic                       pready,
    output logic      [31:0]           prdata,
    output logic                       pslverr,
    // Register side
    input  wire logic [6:0][7:0]       reg_vals,
    output logic      [6:0]            wr_stb
);

    opc_apb_state_t state_q, state_d;
    logic [6:0]     hit_q, hit_d;
    logic           pready_d, pslverr_d;
    logic [31:0]    prdata_d;

    // Decode and read data are taken in the setup cycle so that
    // every answer leaves a flip-flop
    always_comb begin
        state_d   = state_q;
        hit_d     = hit_q;
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        prdata_d  = prdata;
        wr_stb    = '0;
        case (state_q)
            OPC_ST_IDLE: begin
                if (psel && !penable) begin
                    hit_d     = opc_decode(paddr);
                    pready_d  = 1'b1;
                    pslverr_d = (opc_decode(paddr) == '0);
                    prdata_d  = '0;
                    for (int i = 0; i < OPC_NREG; i++) begin
                        if (opc_decode(paddr) == 7'(1 << i)) begin
                            prdata_d = {24'h000000, reg_vals[i]};
                        end
                    end
                    state_d = OPC_ST_ACCESS;
                end
            end
            OPC_ST_ACCESS: begin
                // Unmapped writes are dropped; hit is zero for them
                if (psel && penable && pwrite) begin
                    wr_stb = hit_q;
                end
                state_d = OPC_ST_IDLE;
            end
            default: begin
                state_d = OPC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= OPC_ST_IDLE;
            hit_q   <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            state_q <= state_d;
            hit_q   <= hit_d;
            pready  <= pready_d;
            pslverr <= pslverr_d;
            prdata  <= prdata_d;
        end
    end

endmodule : opc_apb_port
`default_nettype wire

// ==== src/opc_output_path_regs.sv ====
// Summary of operation
// - Power bit 7 powers down left converter, bit 6 the right one
// - Power bits 5..2 enable drivers la, ra, lb, rb; reset disabled
// - Each driver has its own volume register, level in bits 5..0
// - Level code steps 1.5dB from 000000 at -45dB; reset 000000
// - Left mixer bit 7 adds left converter output into left mixer
// - Left mixer bit 6 adds selected left analog input into mix
// - Right mixer bit 7 adds right converter output into right mix
// - Right mixer bit 6 adds selected right analog input into mix
// - Mixer gain in bits 5..3, 000 is +6dB, 111 is -15dB default
// - Left mixer feeds both left drivers, right mixer both right
// - Analog input choice comes from separate source-select inputs
// - Power register resets to 0xc0
// - Both mixer registers reset to 0x38
// - All four volume registers reset to 0x00
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Playback output path control registers
// ==========================================================
module opc_output_path_regs
    import opc_pkg::*;
(
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [OPC_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic      [31:0]           prdata,
    output logic                       pslverr,
    // Source selects held outside this bank
    input  wire logic [OPC_SEL_W-1:0]  left_mixer_source_select,
    input  wire logic [OPC_SEL_W-1:0]  right_mixer_source_select,
    // Settings to the analog path
    output opc_path_cfg_t              path_cfg_q
);

    logic [6:0][7:0] reg_vals;
    logic [6:0]      wr_stb;
    opc_path_cfg_t   path_cfg_d;

    // ==========================================================
    // Bus port
    // ==========================================================
    opc_apb_port u_port (
        .pclk     (pclk),
        .presetn  (presetn),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .pready   (pready),
        .prdata   (prdata),
        .pslverr  (pslverr),
        .reg_vals (reg_vals),
        .wr_stb   (wr_stb)
    );

    // ==========================================================
    // Register array
    // ==========================================================
    // Reset values come from the slot tables
    // Masks keep reserved bits zero
    for (genvar g = 0; g < OPC_NREG; g++) begin : g_reg
        opc_cfg_reg #(
            .RST  (OPC_REG_RST[g]),
            .MASK (OPC_REG_MASK[g])
        ) u_reg (
            .pclk    (pclk),
            .presetn (presetn),
            .wr_en   (wr_stb[g]),
            .wdata   (pwdata[7:0]),
            .value_q (reg_vals[g])
        );
    end

    // ==========================================================
    // Path settings
    // ==========================================================
    // Settings follow a register write by one cycle; the analog
    // side sees glitch-free levels from flip-flops
    always_comb begin
        logic [7:0] pw;
        logic [7:0] ml;
        logic [7:0] mr;
        pw = reg_vals[OPC_SLOT_POWER];
        ml = reg_vals[OPC_SLOT_MIX_L];
        mr = reg_vals[OPC_SLOT_MIX_R];
        path_cfg_d = '0;
        path_cfg_d.left_converter_power_down  = pw[OPC_BIT_LPDN];
        path_cfg_d.right_converter_power_down = pw[OPC_BIT_RPDN];
        for (int i = 0; i < 4; i++) begin
            // Bit 5 is driver la down to bit 2 for rb
            path_cfg_d.drv_enable[i] = pw[OPC_BIT_DRV_EN - i];
            // Code passed as stored, linear in 1.5dB steps
            path_cfg_d.drv_level[i] =
                reg_vals[OPC_SLOT_VOL + i][OPC_LEVEL_W-1:0];
        end
        path_cfg_d.left_converter_to_mixer_enable =
            ml[OPC_BIT_CONV_MIX];
        path_cfg_d.left_input_to_mixer_enable =
            ml[OPC_BIT_IN_MIX];
        path_cfg_d.right_converter_to_mixer_enable =
            mr[OPC_BIT_CONV_MIX];
        path_cfg_d.right_input_to_mixer_enable =
            mr[OPC_BIT_IN_MIX];
        path_cfg_d.left_input_mixer_gain =
            ml[OPC_GAIN_LSB +: OPC_GAIN_W];
        path_cfg_d.right_input_mixer_gain =
            mr[OPC_GAIN_LSB +: OPC_GAIN_W];
        // Drivers la and lb take the left mix, ra and rb the right
        path_cfg_d.drv_mix_gain[0] = ml[OPC_GAIN_LSB +: OPC_GAIN_W];
        path_cfg_d.drv_mix_gain[2] = ml[OPC_GAIN_LSB +: OPC_GAIN_W];
        path_cfg_d.drv_mix_gain[1] = mr[OPC_GAIN_LSB +: OPC_GAIN_W];
        path_cfg_d.drv_mix_gain[3] = mr[OPC_GAIN_LSB +: OPC_GAIN_W];
        // Selected input only reaches a mixer whose input path is on
        path_cfg_d.left_input_route = ml[OPC_BIT_IN_MIX] ?
            left_mixer_source_select : '0;
        path_cfg_d.right_input_route = mr[OPC_BIT_IN_MIX] ?
            right_mixer_source_select : '0;
    end

    // Reset state matches the register reset values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            path_cfg_q <= '{
                left_converter_power_down  : 1'b1,
                right_converter_power_down : 1'b1,
                left_input_mixer_gain      : 3'h7,
                right_input_mixer_gain     : 3'h7,
                drv_mix_gain               : {4{3'h7}},
                default                    : '0};
        end else begin
            path_cfg_q <= path_cfg_d;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic first_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    // Direction folded into the setup sequence, so that no sequence
    // instance ever stands as an operand of a logical and
    sequence s_setup(logic [7:0] idx, logic dir);
        psel && !penable && pwrite == dir &&
        paddr == {2'b00, idx, 2'b00};
    endsequence

    sequence s_write(logic [7:0] idx);
        s_setup(idx, 1'b1) ##1 psel && penable && pready;
    endsequence

    a_power_convs: assert property (
        s_write(OPC_IDX_POWER) |-> ##2
        path_cfg_q.left_converter_power_down == $past(pwdata[7], 2) &&
        path_cfg_q.right_converter_power_down == $past(pwdata[6], 2))
        else $error("converter power bits not taken from write");

    a_driver_enables: assert property (
        s_write(OPC_IDX_POWER) |-> ##2
        path_cfg_q.drv_enable == {$past(pwdata[2], 2), $past(pwdata[3], 2),
                                  $past(pwdata[4], 2), $past(pwdata[5], 2)})
        else $error("driver enables not in bit order 5 to 2");

    a_level_isolated: assert property (
        s_write(OPC_IDX_VOL_RA) |-> ##2
        path_cfg_q.drv_level[1] == $past(pwdata[5:0], 2) &&
        $stable(path_cfg_q.drv_level[0]) &&
        $stable(path_cfg_q.drv_level[2]) &&
        $stable(path_cfg_q.drv_level[3]))
        else $error("volume write touched another driver");

    a_reset_values: assert property (
        first_q |-> reg_vals[OPC_SLOT_POWER] == 8'hc0 &&
        reg_vals[OPC_SLOT_MIX_L] == 8'h38 &&
        reg_vals[OPC_SLOT_MIX_R] == 8'h38)
        else $error("power or mixer reset value wrong");

    a_level_reset: assert property (
        first_q |-> path_cfg_q.drv_level == '0 &&
        reg_vals[6:3] == '0)
        else $error("volume reset value not zero");

    a_left_mixer: assert property (
        s_write(OPC_IDX_MIX_L) |-> ##2
        path_cfg_q.left_converter_to_mixer_enable == $past(pwdata[7], 2) &&
        path_cfg_q.left_input_to_mixer_enable == $past(pwdata[6], 2))
        else $error("left mixer enables wrong");

    a_right_mixer: assert property (
        s_write(OPC_IDX_MIX_R) |-> ##2
        path_cfg_q.right_converter_to_mixer_enable == $past(pwdata[7], 2) &&
        path_cfg_q.right_input_to_mixer_enable == $past(pwdata[6], 2) &&
        path_cfg_q.right_input_mixer_gain == $past(pwdata[5:3], 2))
        else $error("right mixer fields wrong");

    a_mix_feeds: assert property (
        path_cfg_q.drv_mix_gain[0] == path_cfg_q.left_input_mixer_gain &&
        path_cfg_q.drv_mix_gain[2] == path_cfg_q.left_input_mixer_gain &&
        path_cfg_q.drv_mix_gain[1] == path_cfg_q.right_input_mixer_gain &&
        path_cfg_q.drv_mix_gain[3] == path_cfg_q.right_input_mixer_gain)
        else $error("driver not fed by its own side mixer");

    a_input_route: assert property (
        !path_cfg_q.left_input_to_mixer_enable |->
        path_cfg_q.left_input_route == '0)
        else $error("left input routed while path disabled");

    a_reserved_zero: assert property (
        s_setup(OPC_IDX_MIX_L, 1'b0) |-> ##1
        pready && prdata[2:0] == 3'h0 && prdata[31:8] == '0)
        else $error("reserved mixer bits not read as zero");

    a_one_wait: assert property (
        psel && !penable |-> ##1 pready ##1 !pready)
        else $error("access phase not exactly one cycle");

endmodule : opc_output_path_regs
`default_nettype wire

// ==== verification/test_output_path_control_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Self-checking bench for the output path control registers
// ==========================================================
module test_output_path_control_regs
    import opc_pkg::*;
;
    // Clock, reset and bus request
    logic                  pclk;
    logic                  presetn;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [OPC_ADDR_W-1:0] paddr;
    logic [31:0]           pwdata;
    // Bus answer and path settings
    logic                  pready;
    logic [31:0]           prdata;
    logic                  pslverr;
    logic [OPC_SEL_W-1:0]  left_sel;
    logic [OPC_SEL_W-1:0]  right_sel;
    opc_path_cfg_t         path_cfg_q;
    // Bookkeeping
    int                    fail_count;
    int                    tests_run;
    logic [31:0]           rdv;
    logic                  errv;
    opc_path_cfg_t         exp_cfg;

    // Register tables in slot order: power, mixers, four volumes
    logic [7:0] idx_tab [7] = '{OPC_IDX_POWER, OPC_IDX_MIX_L,
        OPC_IDX_MIX_R, OPC_IDX_VOL_LA, OPC_IDX_VOL_RA, OPC_IDX_VOL_LB,
        OPC_IDX_VOL_RB};
    logic [7:0] rst_tab [7] = '{8'hc0, 8'h38, 8'h38, 8'h00, 8'h00,
        8'h00, 8'h00};
    logic [7:0] msk_tab [7] = '{8'hfc, 8'hf8, 8'hf8, 8'h3f, 8'h3f,
        8'h3f, 8'h3f};

    // ==========================================================
    // Device under test
    // ==========================================================
    opc_output_path_regs uut (
        .pclk                      (pclk),
        .presetn                   (presetn),
        .psel                      (psel),
        .penable                   (penable),
        .pwrite                    (pwrite),
        .paddr                     (paddr),
        .pwdata                    (pwdata),
        .pready                    (pready),
        .prdata                    (prdata),
        .pslverr                   (pslverr),
        .left_mixer_source_select  (left_sel),
        .right_mixer_source_select (right_sel),
        .path_cfg_q                (path_cfg_q)
    );

    // Free-running clock, 4 ns period
    initial pclk = 1'b0;
    always #2 pclk = ~pclk;

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [11:0] ba(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction : ba

    // Expected settings straight out of reset
    function automatic opc_path_cfg_t rst_img();
        opc_path_cfg_t c;
        c = '0;
        c.left_converter_power_down  = 1'b1;
        c.right_converter_power_down = 1'b1;
        c.left_input_mixer_gain      = 3'h7;
        c.right_input_mixer_gain     = 3'h7;
        c.drv_mix_gain               = {4{3'h7}};
        return c;
    endfunction : rst_img

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer; request left up so the next may follow at once
    task automatic xfer(input logic wr, input logic [11:0] addr,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic err);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk(64'(pready), 64'h1);
        rd  = prdata;
        err = pslverr;
    endtask : xfer

    // Drop the request, then let the settings output catch up
    task automatic rel();
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        @(posedge pclk);
    endtask : rel

    task automatic wr(input logic [11:0] addr, input logic [31:0] wd);
        xfer(1'b1, addr, wd, rdv, errv);
        rel();
    endtask : wr

    task automatic rd(input logic [11:0] addr, input logic [31:0] exp,
                      input logic exp_err);
        xfer(1'b0, addr, 32'h0, rdv, errv);
        chk(64'(rdv), 64'(exp));
        chk(64'(errv), 64'(exp_err));
    endtask : rd

    task automatic test_done();
        $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done

    // Watchdog; the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        test_done();
    end

    // ==========================================================
    // Test sequence
    // ==========================================================
    initial begin
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = '0;
        pwdata     = '0;
        left_sel   = 2'h2;
        right_sel  = 2'h1;
        fail_count = 0;
        tests_run  = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);

        // Reset values, read back to back
        for (int i = 0; i < 7; i++) begin
            rd(ba(idx_tab[i]), 32'(rst_tab[i]), 1'b0);
        end
        rel();
        chk(64'(path_cfg_q), 64'(rst_img()));
        $display("Test reset values done");

        // All ones back to back; reserved bits must stay clear
        for (int i = 0; i < 7; i++) begin
            xfer(1'b1, ba(idx_tab[i]), 32'hffffffff, rdv, errv);
        end
        for (int i = 0; i < 7; i++) begin
            rd(ba(idx_tab[i]), 32'(msk_tab[i]), 1'b0);
        end
        rel();
        exp_cfg                   = '1;
        exp_cfg.left_input_route  = left_sel;
        exp_cfg.right_input_route = right_sel;
        chk(64'(path_cfg_q), 64'(exp_cfg));
        $display("Test reserved bits done");

        // Mixed settings with boundary level codes
        wr(ba(OPC_IDX_POWER), 32'h28);
        wr(ba(OPC_IDX_MIX_L), 32'h80);
        wr(ba(OPC_IDX_MIX_R), 32'h68);
        wr(ba(OPC_IDX_VOL_LA), 32'h00);
        wr(ba(OPC_IDX_VOL_RA), 32'h1e);
        wr(ba(OPC_IDX_VOL_LB), 32'h21);
        wr(ba(OPC_IDX_VOL_RB), 32'h01);
        exp_cfg                                 = '0;
        exp_cfg.drv_enable                      = 4'b0101;
        exp_cfg.drv_level                       = {6'h01, 6'h21, 6'h1e, 6'h00};
        exp_cfg.left_converter_to_mixer_enable  = 1'b1;
        exp_cfg.right_input_to_mixer_enable     = 1'b1;
        exp_cfg.right_input_mixer_gain          = 3'h5;
        exp_cfg.drv_mix_gain                    = {3'h5, 3'h0, 3'h5, 3'h0};
        exp_cfg.right_input_route               = right_sel;
        chk(64'(path_cfg_q), 64'(exp_cfg));
        $display("Test mixed settings done");

        // Walk each driver enable bit in turn
        for (int i = 0; i < 4; i++) begin
            wr(ba(OPC_IDX_POWER), 32'(8'h20 >> i));
            chk(64'({path_cfg_q.left_converter_power_down,
                     path_cfg_q.right_converter_power_down,
                     path_cfg_q.drv_enable}), 64'(4'h1 << i));
        end
        // Every mixer gain code, seen by both right drivers
        for (int g = 0; g < 8; g++) begin
            wr(ba(OPC_IDX_MIX_R), 32'(g << 3));
            chk(64'(path_cfg_q.right_input_mixer_gain), 64'(g));
            chk(64'({path_cfg_q.drv_mix_gain[3],
                     path_cfg_q.drv_mix_gain[1]}), 64'({2{3'(g)}}));
        end
        $display("Test field walks done");

        // Unmapped and misaligned places refuse and change nothing
        rd(12'h000, 32'h0, 1'b1);
        xfer(1'b1, 12'h014, 32'hff, rdv, errv);
        chk(64'(errv), 64'h1);
        xfer(1'b1, 12'h011, 32'hff, rdv, errv);
        chk(64'(errv), 64'h1);
        rd(ba(OPC_IDX_POWER), 32'h04, 1'b0);
        rel();
        $display("Test unmapped access done");

        // Reset in mid-run restores every default
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(64'(path_cfg_q), 64'(rst_img()));
        rd(ba(OPC_IDX_VOL_LB), 32'h00, 1'b0);
        rel();
        $display("Test second reset done");
        test_done();
    end
endmodule : test_output_path_control_regs
`default_nettype wire
